// ===== dv/ppsam_board.sv
// board model: strap resistors, serial devices, pad wire
`timescale 1ns/1ps
// ========
// board
module ppsam_board
    import ppsam_pkg::*;
(
    input  wire logic [PIO_W-1:0] ext_lvl,
    input  wire logic [PIO_W-1:0] pio_out,
    input  wire logic [PIO_W-1:0] pio_oe,
    output logic      [PIO_W-1:0] pio_in
);
    // device wins where it drives, else straps or serial devices
    assign pio_in = (pio_oe & pio_out) | (~pio_oe & ext_lvl);
endmodule

// ===== dv/ppsam_top_sva.sv
// checker for strap capture and alternate pin functions
`timescale 1ns/1ps
// ========
// checker
module ppsam_top_sva
    import ppsam_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              clk_en,
    input wire logic [PIO_W-1:0]  pio_in,
    input wire logic [PIO_W-1:0]  pio_oe,
    input wire logic              serial_clk,
    input wire logic              internal_serial_clk,
    input wire logic              first_serial_port_txd,
    input wire logic              second_serial_port_rts,
    input wire ppsam_serial_t     first_serial_port_pins,
    input wire ppsam_serial_t     second_serial_port_pins,
    input wire ppsam_strap_t      strap
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // first enabled edge after release captures the straps
    sequence s_release;
        $rose(aresetn) && clk_en;
    endsequence
    property p_width;
        s_release |=> strap.width == ($past(pio_in[1]) ? PPSAM_W32 : $past(pio_in[0]) ? PPSAM_W16 : PPSAM_W8);
    endproperty
    a_width: assert property (p_width) else $error("boot width strap wrong");
    property p_ecc;
        s_release |=> strap.ecc_en == $past(pio_in[2]);
    endproperty
    a_ecc: assert property (p_ecc) else $error("ecc strap wrong");
    // straps never move once captured, whatever the pins do
    // capture marker: set on the first enabled edge after release, when straps are taken
    logic cap;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap <= 1'b0;
        end else if (clk_en) begin
            cap <= 1'b1;
        end
    end
    property p_hold;
        cap |=> $stable(strap);
    endproperty
    a_hold: assert property (p_hold) else $error("strap changed after capture");
    property p_sclk;
        pio_oe[3] |-> serial_clk == internal_serial_clk;
    endproperty
    a_sclk: assert property (p_sclk) else $error("serial clock from driven pin");
    property p_sp2;
        second_serial_port_pins.rts == second_serial_port_rts && (!pio_oe[8] || second_serial_port_pins.cts);
    endproperty
    a_sp2: assert property (p_sp2) else $error("second serial port pins wrong");
    property p_sp1;
        first_serial_port_pins.txd == first_serial_port_txd && (!pio_oe[14] || first_serial_port_pins.rxd);
    endproperty
    a_sp1: assert property (p_sp1) else $error("first serial port pins wrong");
endmodule
bind ppsam_top ppsam_top_sva u_sva (.aclk, .aresetn, .clk_en, .pio_in, .pio_oe, .serial_clk, .internal_serial_clk,
    .first_serial_port_txd, .second_serial_port_rts, .first_serial_port_pins, .second_serial_port_pins, .strap);

// ===== dv/test_ppsam_top.sv
// self-checking bench for the strap and alternate-function mux
`timescale 1ns/1ps
module test_ppsam_top
    import ppsam_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, rd_d;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    logic [PIO_W-1:0] pio_in, pio_out, pio_oe, ext = 16'hffff;
    logic sp1_rts = 1'b0, sp1_txd = 1'b0, sp2_rts = 1'b0, sp2_txd = 1'b0, int_clk = 1'b0, sclk;
    ppsam_serial_t sp1_pins, sp2_pins;
    ppsam_strap_t strap;
    int n_tests = 0;
    int miscompares = 0;
    // rows: strap pins 4:2, expected width code 1:0
    logic [4:0] rows [6] = '{5'h00, 5'h05, 5'h0a, 5'h0e, 5'h15, 5'h1a};
    // 40 ns period
    always #20 aclk = ~aclk;
    ppsam_top DUT (.aclk, .aresetn, .clk_en, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pio_in, .pio_out, .pio_oe,
        .first_serial_port_rts(sp1_rts), .first_serial_port_txd(sp1_txd), .first_serial_port_pins(sp1_pins),
        .second_serial_port_rts(sp2_rts), .second_serial_port_txd(sp2_txd), .second_serial_port_pins(sp2_pins),
        .internal_serial_clk(int_clk), .serial_clk(sclk), .strap);
    ppsam_board u_board (.ext_lvl(ext), .pio_out, .pio_oe, .pio_in);
    task automatic end_sim();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    // write: offer address and data together, hold each until taken
    task automatic wr(logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        wr_r = bresp;
        bready <= 1'b0;
        if (i == 50) begin miscompares++; end_sim(); end
    endtask
    task automatic rd(logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd_d = rdata;
        rd_r = rresp;
        rready <= 1'b0;
        if (i == 50) begin miscompares++; end_sim(); end
    endtask
    // ========
    // main sequence
    initial begin
        for (int k = 0; k < 6; k++) begin
            aresetn <= 1'b0;
            ext[2:0] <= rows[k][4:2];
            repeat (5) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (2) @(posedge aclk);
            chk("strap", {29'h0, strap}, {29'h0, rows[k][1:0], rows[k][4]});
            rd(REG_STRAP);
            chk("strap reg", rd_d, {29'h0, rows[k][1:0], rows[k][4]});
        end
        // pins move after capture, straps must not
        ext[2:0] <= 3'h1;
        repeat (3) @(posedge aclk);
        chk("strap kept", {29'h0, strap}, 32'h5);
        wr(REG_DIR, 32'h7);
        chk("wr resp", {30'h0, wr_r}, {30'h0, RESP_OKAY});
        wr(REG_DATA_OUT, 32'h6);
        rd(REG_PIN_IN);
        chk("pin in", rd_d, 32'hfffe);
        chk("sclk int", {31'h0, sclk}, 32'h0);
        wr(REG_ALT_CTRL, 32'h4);
        chk("sclk pin", {31'h0, sclk}, 32'h1);
        int_clk <= 1'b1;
        ext[3] <= 1'b0;
        @(posedge aclk);
        #1 chk("sclk pin lo", {31'h0, sclk}, 32'h0);
        ext[15:8] <= 8'h96;
        sp2_rts <= 1'b1;
        sp1_txd <= 1'b1;
        wr(REG_DIR, 32'hffff);
        wr(REG_ALT_CTRL, 32'h3);
        chk("sp2 pins", {28'h0, sp2_pins}, 32'h6);
        chk("sp1 pins", {28'h0, sp1_pins}, 32'h9);
        chk("alt oe", {24'h0, pio_oe[15:8]}, 32'haa);
        chk("alt out", {28'h0, pio_out[15], pio_out[13], pio_out[11], pio_out[9]}, 32'h9);
        rd(REG_ALT_CTRL);
        chk("alt reg", rd_d, 32'h3);
        wr(8'h24, 32'h0);
        chk("bad wr resp", {30'h0, wr_r}, {30'h0, RESP_SLVERR});
        rd(REG_DIR);
        chk("dir reg", rd_d, 32'hffff);
        wr(REG_ALT_CTRL, 32'h0);
        chk("sp2 off", {28'h0, sp2_pins}, 32'he);
        chk("sp1 off", {28'h0, sp1_pins}, 32'hb);
        chk("oe off", {16'h0, pio_oe}, 32'hffff);
        rd(8'h20);
        chk("bad resp", {30'h0, rd_r}, {30'h0, RESP_SLVERR});
        chk("bad data", rd_d, 32'h0);
        // mid-run reset: pads fall back to inputs; enable low holds capture and bus
        aresetn <= 1'b0;
        ext[2:0] <= 3'h3;
        repeat (2) @(posedge aclk);
        chk("oe in reset", {16'h0, pio_oe}, 32'h0);
        clk_en <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("strap frozen", {29'h0, strap}, 32'h0);
        fork
            rd(REG_PIN_IN);
            begin
                repeat (4) @(posedge aclk);
                clk_en <= 1'b1;
            end
        join
        chk("pin in late", rd_d, 32'h96f3);
        chk("strap late", {29'h0, strap}, 32'h4);
        end_sim();
    end
endmodule

// ===== src/ppsam_pkg.sv
// package: constants and carriers for the parallel port strap and alternate-function mux
package ppsam_pkg;

    // ==========================================================
    // port geometry
    localparam int PIO_W = 16;

    // ==========================================================
    // strap and alternate serial clock pin positions
    localparam int STRAP_WID_LO  = 0;
    localparam int STRAP_WID_HI  = 1;
    localparam int STRAP_ECC     = 2;
    localparam int ALT_SCLK      = 3;

    // ==========================================================
    // second serial port pins
    localparam int SP2_CTS = 8;
    localparam int SP2_RTS = 9;
    localparam int SP2_RXD = 10;
    localparam int SP2_TXD = 11;

    // ==========================================================
    // first serial port pins
    localparam int SP1_CTS = 12;
    localparam int SP1_RTS = 13;
    localparam int SP1_RXD = 14;
    localparam int SP1_TXD = 15;

    // ==========================================================
    // register map (byte addresses), all of our own choosing
    localparam logic [7:0] REG_DATA_OUT = 8'h00;
    localparam logic [7:0] REG_DIR      = 8'h04;
    localparam logic [7:0] REG_PIN_IN   = 8'h08;
    localparam logic [7:0] REG_ALT_CTRL = 8'h0c;
    localparam logic [7:0] REG_STRAP    = 8'h10;

    // alt control field positions
    localparam int ALT_SP2_EN  = 0;
    localparam int ALT_SP1_EN  = 1;
    localparam int ALT_SCLK_EN = 2;

    // reset values
    localparam logic [15:0] RST_DATA_OUT = 16'h0000;
    localparam logic [15:0] RST_DIR      = 16'h0000;
    localparam logic [2:0]  RST_ALT_CTRL = 3'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // boot memory width codes
    typedef enum logic [1:0] {
        PPSAM_W8  = 2'h0,
        PPSAM_W16 = 2'h1,
        PPSAM_W32 = 2'h2
    } ppsam_width_t;

    // serial port side of the mux
    typedef struct packed {
        logic cts;
        logic rts;
        logic rxd;
        logic txd;
    } ppsam_serial_t;

    // latched strap information
    typedef struct packed {
        ppsam_width_t width;
        logic         ecc_en;
    } ppsam_strap_t;

endpackage

// ===== src/ppsam_top.sv
// parallel port strap sampling, alternate-function mux and axi4-lite register slave
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - at reset release pins 1:0 give boot width: 00=8, 01=16, 1x=32 bits
// - at reset release pin 2 high enables memory error checking
// - pin 3 can replace the internal serial clock as serial port clock
// - pins 8..11 optionally carry second serial port cts, rts, rxd, txd
// - pins 12..15 optionally carry first serial port cts, rts, rxd, txd
module ppsam_top
    import ppsam_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                clk_en,
    // axi4-lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // pads
    input  wire logic [PIO_W-1:0]    pio_in,
    output logic      [PIO_W-1:0]    pio_out,
    output logic      [PIO_W-1:0]    pio_oe,
    // serial ports
    input  wire logic                first_serial_port_rts,
    input  wire logic                first_serial_port_txd,
    output ppsam_serial_t            first_serial_port_pins,
    input  wire logic                second_serial_port_rts,
    input  wire logic                second_serial_port_txd,
    output ppsam_serial_t            second_serial_port_pins,
    input  wire logic                internal_serial_clk,
    output logic                     serial_clk,
    // straps to core and memory controller
    output ppsam_strap_t             strap
);

    // ==========================================================
    // storage
    logic [PIO_W-1:0] data_out;
    logic [PIO_W-1:0] dir;
    logic [2:0]       alt_ctrl;
    logic             strap_done;
    logic             aw_held;
    logic             w_held;
    logic [7:0]       aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic [PIO_W-1:0] alt_mask;
    logic [PIO_W-1:0] alt_oe;
    logic [PIO_W-1:0] alt_val;
    logic             b_pend;
    logic             r_pend;

    // decoding shared by read and write
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == REG_DATA_OUT) || (a == REG_DIR) || (a == REG_PIN_IN) ||
               (a == REG_ALT_CTRL) || (a == REG_STRAP);
    endfunction

    function automatic ppsam_width_t width_decode(input logic [1:0] p);
        if (p[1])
            return PPSAM_W32;
        else if (p[0])
            return PPSAM_W16;
        else
            return PPSAM_W8;
    endfunction

    // ==========================================================
    // strap capture: first enabled edge after release, never again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_done <= 1'b0;
            strap      <= '{PPSAM_W8, 1'b0};
        end else if (clk_en && !strap_done) begin
            strap_done   <= 1'b1;
            strap.width  <= width_decode(pio_in[STRAP_WID_HI:STRAP_WID_LO]);
            strap.ecc_en <= pio_in[STRAP_ECC];
        end
    end

    // ==========================================================
    // alternate function mux; pins are inputs (oe low) during reset so straps read clean
    always_comb begin
        alt_mask = '0;
        alt_oe   = '0;
        alt_val  = '0;
        if (alt_ctrl[ALT_SP2_EN]) begin
            alt_mask[SP2_TXD:SP2_CTS] = 4'hf;
            alt_oe[SP2_RTS] = 1'b1;
            alt_oe[SP2_TXD] = 1'b1;
            alt_val[SP2_RTS] = second_serial_port_rts;
            alt_val[SP2_TXD] = second_serial_port_txd;
        end
        if (alt_ctrl[ALT_SP1_EN]) begin
            alt_mask[SP1_TXD:SP1_CTS] = 4'hf;
            alt_oe[SP1_RTS] = 1'b1;
            alt_oe[SP1_TXD] = 1'b1;
            alt_val[SP1_RTS] = first_serial_port_rts;
            alt_val[SP1_TXD] = first_serial_port_txd;
        end
        if (alt_ctrl[ALT_SCLK_EN])
            alt_mask[ALT_SCLK] = 1'b1;
    end

    // per-pin selection between gpio and alternate use
    genvar g;
    generate
        for (g = 0; g < PIO_W; g++) begin : g_pin
            assign pio_out[g] = alt_mask[g] ? alt_val[g] : data_out[g];
            assign pio_oe[g]  = strap_done & (alt_mask[g] ? alt_oe[g] : dir[g]);
        end
    endgenerate

    // inputs toward the serial ports; cts idles high when not muxed
    assign second_serial_port_pins = '{alt_ctrl[ALT_SP2_EN] ? pio_in[SP2_CTS] : 1'b1,
                                       second_serial_port_rts,
                                       alt_ctrl[ALT_SP2_EN] ? pio_in[SP2_RXD] : 1'b1,
                                       second_serial_port_txd};
    assign first_serial_port_pins  = '{alt_ctrl[ALT_SP1_EN] ? pio_in[SP1_CTS] : 1'b1,
                                       first_serial_port_rts,
                                       alt_ctrl[ALT_SP1_EN] ? pio_in[SP1_RXD] : 1'b1,
                                       first_serial_port_txd};
    // clock is a plain mux; glitches on switching are software's concern
    assign serial_clk = alt_ctrl[ALT_SCLK_EN] ? pio_in[ALT_SCLK] : internal_serial_clk;

    // ==========================================================
    // axi write: address and data caught in either order
    // handshakes masked while the enable is low, so no transfer completes on a frozen edge
    assign s_axi_awready = clk_en && !aw_held && !b_pend;
    assign s_axi_wready  = clk_en && !w_held && !b_pend;
    assign s_axi_bvalid  = clk_en && b_pend;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
        end
    end

    // register update and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_out     <= RST_DATA_OUT;
            dir          <= RST_DIR;
            alt_ctrl     <= RST_ALT_CTRL;
            b_pend       <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (clk_en) begin
            if (aw_held && w_held) begin
                b_pend       <= 1'b1;
                s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
                case (aw_addr)
                    REG_DATA_OUT: begin
                        if (w_strb[0]) data_out[7:0]  <= w_data[7:0];
                        if (w_strb[1]) data_out[15:8] <= w_data[15:8];
                    end
                    REG_DIR: begin
                        if (w_strb[0]) dir[7:0]  <= w_data[7:0];
                        if (w_strb[1]) dir[15:8] <= w_data[15:8];
                    end
                    REG_ALT_CTRL: begin
                        if (w_strb[0]) alt_ctrl <= w_data[2:0];
                    end
                    default: begin
                    end
                endcase
            end else if (s_axi_bready) begin
                b_pend <= 1'b0;
            end
        end
    end

    // ==========================================================
    // axi read: one cycle from accept to rvalid
    assign s_axi_arready = clk_en && !r_pend;
    assign s_axi_rvalid  = clk_en && r_pend;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_pend       <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                r_pend       <= 1'b1;
                s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                case (s_axi_araddr)
                    REG_DATA_OUT: s_axi_rdata <= {16'h0000, data_out};
                    REG_DIR:      s_axi_rdata <= {16'h0000, dir};
                    REG_PIN_IN:   s_axi_rdata <= {16'h0000, pio_in};
                    REG_ALT_CTRL: s_axi_rdata <= {29'h0000_0000, alt_ctrl};
                    REG_STRAP:    s_axi_rdata <= {29'h0000_0000, strap.width, strap.ecc_en};
                    default:      s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                r_pend <= 1'b0;
            end
        end
    end

endmodule
